// File: hw/video_clamp_and_format_ctrl.sv
/*
 Clamp timing, input mode control, 4:2:2 decimation and slicer settings
 for a triple-channel digitizer, with an APB register slave and an
 output FIFO. Assumes one pixel per clock_i cycle when pix_valid_i and
 pix_ready_o are high, samples already synchronous to clock_i, and hsync_i active high.
*/
// Design decision made here: the APB register port.
`timescale 1ns/100ps

module pixel_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_b_i,
    // Fill side
    input wire logic in_valid_i,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic in_ready_o,
    // Drain side
    output logic out_valid_o,
    output logic [WIDTH-1:0] out_data_o,
    input wire logic out_ready_i
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    // Pointer wrap relies on a power-of-two depth
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("pixel_fifo depth must be a power of two");
    end

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wptr;
        logic [AW-1:0] rptr;
        logic [CW-1:0] count;
        logic ready;
        logic valid;
        logic [WIDTH-1:0] data;
    } fifo_state_t;

    fifo_state_t s_reg;
    fifo_state_t s_next;
    logic push;
    logic pop;

    // Output stage is a register so the drain side sees flop outputs
    always_comb begin
        s_next = s_reg;
        push = in_valid_i && s_reg.ready;
        pop = (s_reg.count != '0) && (!s_reg.valid || out_ready_i);
        if (out_ready_i) begin
            s_next.valid = 1'b0;
        end
        if (pop) begin
            s_next.data = s_reg.mem[s_reg.rptr];
            s_next.valid = 1'b1;
            s_next.rptr = s_reg.rptr + AW'(1);
        end
        if (push) begin
            s_next.mem[s_reg.wptr] = in_data_i;
            s_next.wptr = s_reg.wptr + AW'(1);
        end
        s_next.count = s_reg.count + CW'(push) - CW'(pop);
        s_next.ready = (s_next.count < CW'(DEPTH)); // Back-pressure to the source
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign in_ready_o = s_reg.ready;
    assign out_valid_o = s_reg.valid;
    assign out_data_o = s_reg.data;
endmodule : pixel_fifo

module video_clamp_and_format_ctrl
    import video_clamp_pkg::*;
#(
    parameter int ADDR_W = 12,
    parameter int DEPTH = FIFO_DEPTH
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_b_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Digitized samples and timing
    input wire logic pix_valid_i,
    input wire pixel_t pix_i,
    output logic pix_ready_o,
    input wire logic hsync_i,
    input wire logic coast_i,
    // Formatted stream to the video processor
    output logic out_valid_o,
    output pixel_t out_pix_o,
    input wire logic out_ready_i,
    // Analog controls
    output logic clamp_o,
    output logic dc_coupled_o,
    output logic [3:0] slicer_threshold_o,
    output logic [1:0] slicer_hyst_o,
    output logic slicer_lpf_o,
    output logic tri_level_o
);
    if (ADDR_W < 10) begin : g_bad_addr
        $error("address must reach the highest register index");
    end

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic [7:0] input_configuration;
        logic [7:0] clamp_start_pixel_high;
        logic [7:0] clamp_start_pixel_low;
        logic [7:0] clamp_width_pixels;
        logic [7:0] output_format_control;
        logic [7:0] slicer_control_a;
        logic [7:0] slicer_control_b;
        logic [7:0] clamp_coast_control;
        clamp_state_t clamp_state;
        logic hsync_d;
        logic [15:0] pix_cnt;
        logic [7:0] clamp_left;
        logic odd_px;
        logic [7:0] held_v;
        logic tri_seen;
        logic tri_level;
        logic clamp;
    } ctrl_state_t;

    localparam ctrl_state_t RESET_STATE = '{
        input_configuration: RST_INPUT_CFG,
        clamp_start_pixel_high: RST_START_HIGH,
        clamp_start_pixel_low: RST_START_LOW,
        clamp_width_pixels: RST_CLAMP_WIDTH,
        output_format_control: RST_OUT_FORMAT,
        slicer_control_a: RST_SLICER_A,
        slicer_control_b: RST_SLICER_B,
        clamp_coast_control: RST_CLAMP_COAST,
        clamp_state: CLAMP_IDLE,
        default: '0
    };

    ctrl_state_t s_reg;
    ctrl_state_t s_next;
    pixel_t fmt_pix;
    logic fifo_ready;
    logic px;
    logic trail;
    logic [7:0] idx;
    logic [7:0] u_smp;
    logic [7:0] v_smp;
    logic allow;

    // Word index from a byte address; unaligned bits are ignored
    function automatic logic [7:0] reg_index(input logic [ADDR_W-1:0] a);
        reg_index = a[9:2];
    endfunction : reg_index

    // Chroma shift; samples in this mode are signed around black
    function automatic logic [7:0] chroma_black(input logic [7:0] x, input logic on);
        chroma_black = on ? (x + CHROMA_MID) : x;
    endfunction : chroma_black

    always_comb begin
        s_next = s_reg;
        idx = reg_index(paddr_i);
        px = pix_valid_i && fifo_ready;
        trail = s_reg.hsync_d && !hsync_i;
        allow = s_reg.clamp_coast_control[BIT_COAST_CLAMP];
        s_next.hsync_d = hsync_i;

        // APB: answer is ready in the first access cycle
        s_next.pready = psel_i && !penable_i;
        s_next.pslverr = 1'b0;
        s_next.prdata = '0;
        if (psel_i && !penable_i) begin
            case (idx)
                IDX_INPUT_CFG: s_next.prdata[7:0] = s_reg.input_configuration;
                IDX_START_HIGH: s_next.prdata[7:0] = s_reg.clamp_start_pixel_high;
                IDX_START_LOW: s_next.prdata[7:0] = s_reg.clamp_start_pixel_low;
                IDX_CLAMP_WIDTH: s_next.prdata[7:0] = s_reg.clamp_width_pixels;
                IDX_OUT_FORMAT: s_next.prdata[7:0] = s_reg.output_format_control;
                IDX_SLICER_A: s_next.prdata[7:0] = s_reg.slicer_control_a;
                IDX_SLICER_B: s_next.prdata[7:0] = s_reg.slicer_control_b;
                IDX_CLAMP_COAST: s_next.prdata[7:0] = s_reg.clamp_coast_control;
                IDX_STATUS: begin
                    // A refused write answers with zero data, like any other error
                    if (!pwrite_i) begin
                        s_next.prdata[3:0] = {fifo_ready, s_reg.tri_level,
                                              s_reg.clamp_state != CLAMP_IDLE, s_reg.clamp};
                    end
                    s_next.pslverr = pwrite_i; // Status is read-only
                end
                default: s_next.pslverr = 1'b1;
            endcase
        end
        // Writes take effect only on the completing access edge
        if (psel_i && penable_i && s_reg.pready && pwrite_i) begin
            case (idx)
                IDX_INPUT_CFG: s_next.input_configuration = pwdata_i[7:0];
                IDX_START_HIGH: s_next.clamp_start_pixel_high = pwdata_i[7:0];
                IDX_START_LOW: s_next.clamp_start_pixel_low = pwdata_i[7:0];
                IDX_CLAMP_WIDTH: s_next.clamp_width_pixels = pwdata_i[7:0];
                IDX_OUT_FORMAT: s_next.output_format_control = pwdata_i[7:0];
                IDX_SLICER_A: s_next.slicer_control_a = pwdata_i[7:0];
                IDX_SLICER_B: s_next.slicer_control_b = pwdata_i[7:0];
                IDX_CLAMP_COAST: s_next.clamp_coast_control = pwdata_i[7:0];
                default: ;
            endcase
        end

        // Clamp sequencing, one pass per line
        if (px) begin
            s_next.pix_cnt = s_reg.pix_cnt + 16'h0001;
        end
        unique case (s_reg.clamp_state)
            CLAMP_IDLE: ;
            CLAMP_WAIT: begin
                if (coast_i && !allow) begin
                    s_next.clamp_state = CLAMP_IDLE;
                end else if (px && s_reg.pix_cnt == {s_reg.clamp_start_pixel_high,
                                                     s_reg.clamp_start_pixel_low}) begin
                    s_next.clamp_left = s_reg.clamp_width_pixels;
                    s_next.clamp_state = (s_reg.clamp_width_pixels != 8'h00) ?
                                         CLAMP_ON : CLAMP_IDLE;
                end
            end
            CLAMP_ON: begin
                if (coast_i && !allow) begin
                    s_next.clamp_state = CLAMP_IDLE;
                end else if (px) begin
                    s_next.clamp_left = s_reg.clamp_left - 8'h01;
                    if (s_reg.clamp_left == 8'h01) begin
                        s_next.clamp_state = CLAMP_IDLE;
                    end
                end
            end
            default: s_next.clamp_state = CLAMP_IDLE;
        endcase
        if (trail) begin
            s_next.pix_cnt = 16'h0000;
            s_next.odd_px = 1'b0;
            s_next.clamp_state = (!s_reg.input_configuration[BIT_DC_COUPLED] &&
                                  (!coast_i || allow)) ? CLAMP_WAIT : CLAMP_IDLE;
            s_next.tri_level = s_reg.tri_seen;
            s_next.tri_seen = 1'b0;
        end
        s_next.clamp = (s_next.clamp_state == CLAMP_ON);

        // Tri-level check on digitized green during sync
        if (px && hsync_i && pix_i.green > TRI_LEVEL_CODE) begin
            s_next.tri_seen = 1'b1;
        end

        // Formatting; no conversion, codes pass in their own space
        u_smp = chroma_black(pix_i.blue, s_reg.input_configuration[BIT_COLOR_DIFF]);
        v_smp = chroma_black(pix_i.red, s_reg.input_configuration[BIT_COLOR_DIFF]);
        fmt_pix.green = pix_i.green;
        if (s_reg.output_format_control[BIT_DECIMATE]) begin
            fmt_pix.blue = 8'h00;
            fmt_pix.red = s_reg.odd_px ? s_reg.held_v : u_smp;
        end else begin
            fmt_pix.blue = u_smp;
            fmt_pix.red = v_smp;
        end
        if (px && !trail) begin
            s_next.odd_px = !s_reg.odd_px;
            if (!s_reg.odd_px) begin
                s_next.held_v = v_smp;
            end
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s_reg <= RESET_STATE;
        end else begin
            s_reg <= s_next;
        end
    end

    // Output buffer; a stalled consumer backs up to pix_ready_o
    pixel_fifo #(
        .WIDTH($bits(pixel_t)),
        .DEPTH(DEPTH)
    ) u_fifo (
        .clock_i(clock_i),
        .rst_b_i(rst_b_i),
        .in_valid_i(pix_valid_i),
        .in_data_i(fmt_pix),
        .in_ready_o(fifo_ready),
        .out_valid_o(out_valid_o),
        .out_data_o(out_pix_o),
        .out_ready_i(out_ready_i)
    );

    // Register-backed outputs
    assign pix_ready_o = fifo_ready;
    assign prdata_o = s_reg.prdata;
    assign pready_o = s_reg.pready;
    assign pslverr_o = s_reg.pslverr;
    assign clamp_o = s_reg.clamp;
    assign dc_coupled_o = s_reg.input_configuration[BIT_DC_COUPLED];
    assign slicer_threshold_o = s_reg.slicer_control_a[THRESH_LSB+:4];
    assign slicer_hyst_o = s_reg.slicer_control_b[HYST_LSB+:2];
    assign slicer_lpf_o = s_reg.slicer_control_b[BIT_LPF_EN];
    assign tri_level_o = s_reg.tri_level;
endmodule : video_clamp_and_format_ctrl

// File: inc/video_clamp_pkg.sv
/*
 Package for the clamp and format controller: register indices, field
 positions, reset values, the clamp states and the carried pixel word.
 Assumes an APB register port with 32-bit data, one register per word.
*/
package video_clamp_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_INPUT_CFG = 8'h10;
    localparam logic [7:0] IDX_START_HIGH = 8'h24;
    localparam logic [7:0] IDX_START_LOW = 8'h25;
    localparam logic [7:0] IDX_CLAMP_WIDTH = 8'h26;
    localparam logic [7:0] IDX_OUT_FORMAT = 8'h28;
    localparam logic [7:0] IDX_SLICER_A = 8'h30;
    localparam logic [7:0] IDX_SLICER_B = 8'h31;
    localparam logic [7:0] IDX_CLAMP_COAST = 8'h60;
    localparam logic [7:0] IDX_STATUS = 8'h70;

    // Field positions
    localparam int BIT_DC_COUPLED = 3;
    localparam int BIT_COLOR_DIFF = 4;
    localparam int BIT_DECIMATE = 0;
    localparam int BIT_COAST_CLAMP = 2;
    localparam int BIT_LPF_EN = 0;
    localparam int HYST_LSB = 1;
    localparam int THRESH_LSB = 0;

    // Values after reset
    localparam logic [7:0] RST_INPUT_CFG = 8'h00;
    localparam logic [7:0] RST_START_HIGH = 8'h00;
    localparam logic [7:0] RST_START_LOW = 8'h08;
    localparam logic [7:0] RST_CLAMP_WIDTH = 8'h10;
    localparam logic [7:0] RST_OUT_FORMAT = 8'h00;
    localparam logic [7:0] RST_SLICER_A = 8'h00;
    localparam logic [7:0] RST_SLICER_B = 8'h00;
    localparam logic [7:0] RST_CLAMP_COAST = 8'h00;

    // Chroma black level in colour-difference mode
    localparam logic [7:0] CHROMA_MID = 8'h80;
    // Green code above which a sync-time sample counts as tri-level
    localparam logic [7:0] TRI_LEVEL_CODE = 8'hA0;
    localparam int FIFO_DEPTH = 16;

    typedef enum logic [1:0] {
        CLAMP_IDLE = 2'b00,
        CLAMP_WAIT = 2'b01,
        CLAMP_ON = 2'b10
    } clamp_state_t;

    typedef struct packed {
        logic [7:0] red;
        logic [7:0] green;
        logic [7:0] blue;
    } pixel_t;

endpackage : video_clamp_pkg

// File: tb/tb.sv
/*
 Bench: APB registers, formatting in all modes, clamp timing, buffer fill
 and drain, tri-level. Assumes package, design, sink and checker.
*/
`timescale 1ns/100ps
module tb;
    import video_clamp_pkg::*;
    logic clock_i, rst_b_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic pix_valid_i = 1'b0, hsync_i = 1'b0, coast_i = 1'b0, src_on = 1'b0, stall = 1'b0;
    logic pready_o, pslverr_o, pix_ready_o, out_valid_o, out_ready_i, clamp_o, dc_coupled_o;
    logic slicer_lpf_o, tri_level_o, got, odd, cd, dec, err;
    logic [1:0] slicer_hyst_o, stall_mode = 2'h0;
    logic [3:0] slicer_threshold_o;
    logic [7:0] v_prev, wv[8];
    logic [8:0] g_force = 9'h000;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h0, prdata_o, rd, rnd;
    pixel_t pix_i = 24'h0, out_pix_o, got_pix, exp_q[$];
    int mismatches = 0, checked = 0, seed = 32'hF5B4, taken, on_cnt, rise_at;
    logic [7:0] idx_t[8] = '{IDX_INPUT_CFG, IDX_START_HIGH, IDX_START_LOW, IDX_CLAMP_WIDTH,
        IDX_OUT_FORMAT, IDX_SLICER_A, IDX_SLICER_B, IDX_CLAMP_COAST};
    logic [7:0] rst_t[8] = '{RST_INPUT_CFG, RST_START_HIGH, RST_START_LOW, RST_CLAMP_WIDTH,
        RST_OUT_FORMAT, RST_SLICER_A, RST_SLICER_B, RST_CLAMP_COAST};

    video_clamp_and_format_ctrl dut (.clock_i(clock_i), .rst_b_i(rst_b_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .pix_valid_i(pix_valid_i), .pix_i(pix_i), .pix_ready_o(pix_ready_o),
        .hsync_i(hsync_i), .coast_i(coast_i), .out_valid_o(out_valid_o),
        .out_pix_o(out_pix_o), .out_ready_i(out_ready_i), .clamp_o(clamp_o),
        .dc_coupled_o(dc_coupled_o), .slicer_threshold_o(slicer_threshold_o),
        .slicer_hyst_o(slicer_hyst_o), .slicer_lpf_o(slicer_lpf_o), .tri_level_o(tri_level_o));
    video_sink sink (.clock_i(clock_i), .rst_b_i(rst_b_i), .valid_i(out_valid_o),
        .pix_i(out_pix_o), .ready_o(out_ready_i), .stall_i(stall), .got_o(got),
        .got_pix_o(got_pix));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic conclude();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : conclude

    // Expected word for one accepted pixel; tracks 4:2:2 parity
    function automatic pixel_t fmt(input pixel_t p);
        pixel_t q;
        logic [7:0] v;
        q = p;
        if (cd) begin
            q.red = p.red + CHROMA_MID;
            q.blue = p.blue + CHROMA_MID;
        end
        v = q.red;
        if (dec) begin
            q.red = odd ? v_prev : q.blue;
            q.blue = 8'h00;
            if (!odd)
                v_prev = v;
            odd = !odd;
        end
        return q;
    endfunction : fmt

    // One APB transfer plus an idle cycle; entered just after a rising edge
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        int n;
        n = 0;
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= {2'h0, idx, 2'h0};
        pwdata_i <= {24'h0, wd};
        @(posedge clock_i);
        penable_i <= 1'b1;
        do begin
            @(posedge clock_i);
            n++;
        end while (pready_o !== 1'b1);
        rd = prdata_o;
        err = pslverr_o;
        check("apb wait", n, 1);
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge clock_i);
    endtask : apb

    // One line: quiet sync pulse, then a pixel run; clamp start counted in taken pixels, width in clocks
    task automatic line(input logic [15:0] start, input logic [7:0] width, input logic coast,
        input logic exp_on, input logic chk);
        src_on <= 1'b0;
        repeat (3) @(posedge clock_i);
        hsync_i <= 1'b1;
        coast_i <= coast;
        repeat (4) @(posedge clock_i);
        hsync_i <= 1'b0;
        repeat (2) @(posedge clock_i);
        odd = 1'b0;
        taken = 0;
        on_cnt = 0;
        src_on <= 1'b1;
        repeat (start + width + 20) @(posedge clock_i);
        src_on <= 1'b0;
        coast_i <= 1'b0;
        repeat (40) @(posedge clock_i);
        if (chk)
            check("clamp width", on_cnt, exp_on ? width : 8'h0);
        if (chk && exp_on)
            check("clamp start", rise_at == start || rise_at == start + 1, 1'b1);
    endtask : line

    initial begin
        clock_i = 1'b0;
        forever #4 clock_i = ~clock_i;
    end

    // Source holds a pixel until taken; also watches the clamp and drives stalls
    always @(posedge clock_i) begin
        if (clamp_o === 1'b1) begin
            if (on_cnt == 0)
                rise_at = taken;
            on_cnt++;
        end
        if (pix_valid_i && pix_ready_o) begin
            taken++;
            exp_q.push_back(fmt(pix_i));
            rnd = $random(seed);
            if (g_force[8])
                rnd[15:8] = g_force[7:0];
            pix_i <= rnd[23:0];
        end
        rnd = $random(seed);
        stall <= stall_mode[1] || (stall_mode[0] && rnd[0]);
        pix_valid_i <= src_on;
    end

    // Every word the consumer accepts must match the oldest expectation
    always @(negedge clock_i) begin
        if (got === 1'b1)
            check("pixel", got_pix, exp_q.pop_front());
    end

    // Hang guard, several times the expected run
    initial begin
        #80000;
        mismatches++;
        conclude();
    end

    initial begin
        repeat (3) @(posedge clock_i);
        rst_b_i <= 1'b1;
        @(posedge clock_i);
        foreach (idx_t[i]) begin
            apb(1'b0, idx_t[i], 8'h00);
            check("reset value", rd, rst_t[i]);
            wv[i] = $random(seed);
        end
        foreach (idx_t[i])
            apb(1'b1, idx_t[i], wv[i]);
        foreach (idx_t[i]) begin
            apb(1'b0, idx_t[i], 8'h00);
            check("readback", rd, wv[i]);
        end
        check("dc coupled", dc_coupled_o, wv[0][3]);
        check("threshold", slicer_threshold_o, wv[5][3:0]);
        check("filter", {slicer_hyst_o, slicer_lpf_o}, wv[6][2:0]);
        apb(1'b0, 8'h11, 8'h00);
        check("unmapped error", err, 1'b1);
        apb(1'b1, IDX_STATUS, 8'hFF);
        check("status write error", err, 1'b1);
        // Every colour mode and output format, with varied clamp timing
        for (int m = 0; m < 4; m++) begin
            cd = m[0];
            dec = m[1];
            apb(1'b1, IDX_INPUT_CFG, {3'h0, cd, 4'h0});
            apb(1'b1, IDX_OUT_FORMAT, {7'h0, dec});
            apb(1'b1, IDX_START_HIGH, 8'h00);
            apb(1'b1, IDX_START_LOW, 8'h03 + m[7:0]);
            apb(1'b1, IDX_CLAMP_WIDTH, 8'h04 + m[7:0]);
            line(16'h3 + m[15:0], 8'h04 + m[7:0], 1'b0, 1'b1, 1'b1);
        end
        apb(1'b1, IDX_START_LOW, 8'h03);
        apb(1'b1, IDX_CLAMP_WIDTH, 8'h00);
        line(16'h3, 8'h0, 1'b0, 1'b0, 1'b1);
        apb(1'b1, IDX_CLAMP_WIDTH, 8'h04);
        stall_mode <= 2'h1;
        line(16'h3, 8'h4, 1'b0, 1'b1, 1'b0);
        // Consumer blocked: buffer must refuse, then drain fully
        stall_mode <= 2'h2;
        src_on <= 1'b1;
        repeat (40) @(posedge clock_i);
        check("fifo full", pix_ready_o, 1'b0);
        src_on <= 1'b0;
        stall_mode <= 2'h0;
        repeat (60) @(posedge clock_i);
        check("fifo drained", exp_q.size(), 0);
        cd = 1'b0;
        apb(1'b1, IDX_INPUT_CFG, 8'h08);
        line(16'h3, 8'h4, 1'b0, 1'b0, 1'b1);
        apb(1'b1, IDX_INPUT_CFG, 8'h00);
        apb(1'b1, IDX_CLAMP_COAST, 8'h00);
        line(16'h3, 8'h4, 1'b1, 1'b0, 1'b1);
        apb(1'b1, IDX_CLAMP_COAST, 8'h04);
        line(16'h3, 8'h4, 1'b1, 1'b1, 1'b1);
        apb(1'b1, IDX_START_HIGH, 8'h01);
        apb(1'b1, IDX_START_LOW, 8'h23);
        line(16'h0123, 8'h4, 1'b0, 1'b1, 1'b1);
        // Bright then dim green during sync, in 4:4:4
        dec = 1'b0;
        apb(1'b1, IDX_OUT_FORMAT, 8'h00);
        for (int t = 1; t >= 0; t--) begin
            g_force = t[0] ? 9'h1F0 : 9'h110;
            pix_i <= {8'h00, g_force[7:0], 8'h00};
            src_on <= 1'b1;
            hsync_i <= 1'b1;
            repeat (6) @(posedge clock_i);
            hsync_i <= 1'b0;
            repeat (3) @(posedge clock_i);
            check("tri level", tri_level_o, t[0]);
            src_on <= 1'b0;
            repeat (40) @(posedge clock_i);
        end
        conclude();
    end
endmodule : tb

// File: tb/video_clamp_checker.sv
/*
 Port assertions for the clamp and format controller.
 Assumes the package is compiled first; bound to the top module.
*/
`timescale 1ns/100ps
module video_clamp_checker
    import video_clamp_pkg::*;
(
    // Watched ports
    input wire logic clock_i,
    input wire logic rst_b_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic pix_valid_i,
    input wire logic pix_ready_o,
    input wire logic hsync_i,
    input wire logic out_valid_o,
    input wire pixel_t out_pix_o,
    input wire logic out_ready_i,
    input wire logic clamp_o,
    input wire logic dc_coupled_o,
    input wire logic [3:0] slicer_threshold_o,
    input wire logic tri_level_o
);
    // One clock domain, so one default clock and reset
    default clocking main_cb @(posedge clock_i);
    endclocking
    default disable iff (!rst_b_i);

    property p_ready_zero_wait; psel_i && !penable_i |=> pready_o; endproperty
    a_ready_zero_wait: assert property (p_ready_zero_wait) else $error("pready late");
    property p_ready_pulse; pready_o |=> !pready_o; endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("pready held");
    property p_err_data; pslverr_o |-> pready_o && prdata_o == 32'h0; endproperty
    a_err_data: assert property (p_err_data) else $error("bad error answer");
    property p_rdata_upper; pready_o |-> prdata_o[31:8] == 24'h0; endproperty
    a_rdata_upper: assert property (p_rdata_upper) else $error("upper read bits");
    // Mode pins move only after a register write
    property p_cfg_by_write;
        $changed({dc_coupled_o, slicer_threshold_o}) |-> $past(psel_i && penable_i && pwrite_i)
            || $past(psel_i && penable_i && pwrite_i, 2);
    endproperty
    a_cfg_by_write: assert property (p_cfg_by_write) else $error("config moved");
    property p_out_hold; out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_pix_o);
    endproperty
    a_out_hold: assert property (p_out_hold) else $error("output dropped");
    property p_clamp_rise; $rose(clamp_o) |-> $past(pix_valid_i && pix_ready_o) && !hsync_i;
    endproperty
    a_clamp_rise: assert property (p_clamp_rise) else $error("clamp start");
    property p_clamp_ac; clamp_o |-> !dc_coupled_o; endproperty
    a_clamp_ac: assert property (p_clamp_ac) else $error("clamp in DC");
    property p_tri_edge; $changed(tri_level_o) |-> $past(hsync_i, 2) && !$past(hsync_i);
    endproperty
    a_tri_edge: assert property (p_tri_edge) else $error("tri update");
endmodule : video_clamp_checker

bind video_clamp_and_format_ctrl video_clamp_checker chk (.clock_i(clock_i),
    .rst_b_i(rst_b_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .pix_valid_i(pix_valid_i), .pix_ready_o(pix_ready_o), .hsync_i(hsync_i),
    .out_valid_o(out_valid_o), .out_pix_o(out_pix_o), .out_ready_i(out_ready_i),
    .clamp_o(clamp_o), .dc_coupled_o(dc_coupled_o),
    .slicer_threshold_o(slicer_threshold_o), .tri_level_o(tri_level_o));

// File: tb/video_sink.sv
/*
 Downstream pixel consumer: stalls on command, reports each accepted word.
 Assumes the bench reads its report away from the rising edge.
*/
`timescale 1ns/100ps
module video_sink
    import video_clamp_pkg::*;
(
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_b_i,
    // Stream in
    input wire logic valid_i,
    input wire pixel_t pix_i,
    output logic ready_o,
    // Bench control and report
    input wire logic stall_i,
    output logic got_o,
    output pixel_t got_pix_o
);
    // Ready lags the stall request a clock, like a registered consumer
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ready_o <= 1'b0;
            got_o <= 1'b0;
            got_pix_o <= 24'h0;
        end else begin
            ready_o <= !stall_i;
            got_o <= valid_i && ready_o;
            got_pix_o <= pix_i;
        end
    end
endmodule : video_sink
